// ---- shared/cebi_pkg.sv ----
// shared constants, codes and state type of the external bus unit
package cebi_pkg;
	localparam int          ADDR_W        = 32;     // address width on the shared pins
	localparam int          DATA_W        = 32;     // data width on the shared pins
	localparam int          WQ_DEPTH      = 4;      // write queue entries
	localparam int          RB_DEPTH      = 4;      // read buffer entries
	localparam int          QUAD_WORDS    = 4;      // words in one instruction line
	localparam int          REGION_BITS   = 3;      // top address bits picking a port region
	localparam int          REGIONS       = 8;      // number of port size regions
	localparam logic [1:0]  PSZ_32        = 2'h0;   // 32-bit memory port
	localparam logic [1:0]  PSZ_16        = 2'h1;   // 16-bit memory port
	localparam logic [1:0]  PSZ_8         = 2'h2;   // 8-bit memory port
	localparam logic [3:0]  STEP_32       = 4'h4;   // low address step, 32-bit port
	localparam logic [3:0]  STEP_16       = 4'h2;   // low address step, 16-bit port
	localparam logic [3:0]  STEP_8        = 4'h1;   // low address step, 8-bit port
	localparam logic [3:0]  LO_QUAD_START = 4'h0;   // low address counter start for quad reads
	localparam logic [3:0]  BE_ALL        = 4'hf;   // all byte lanes
	localparam logic [31:0] RST_WORD      = 32'h0;  // word registers after reset
	localparam logic [3:0]  RST_LO        = 4'h0;   // low address after reset
	localparam logic [3:0]  RST_BEAT      = 4'h0;   // beat counter after reset
	localparam logic [1:0]  RST_REL       = 2'h0;   // release counter after reset
	localparam logic        RST_PH        = 1'b0;   // clock divider phase after reset
	// bus sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_HOLD  = 7'h04,
		ST_XFER  = 7'h08,
		ST_RECOV = 7'h10,
		ST_REL   = 7'h20,
		ST_DMA   = 7'h40
	} cebi_state_e;
endpackage

// ---- rtl/cebi_bus_unit.sv ----
// external bus unit: write queue, read buffer, port sizing, dma grant
`timescale 1ns/1ps
module cebi_bus_unit #(
	parameter int WQ_D = cebi_pkg::WQ_DEPTH,    // write queue depth
	parameter int RB_D = cebi_pkg::RB_DEPTH     // read buffer depth
) (
	input  wire logic                          I_CORE_CLK,
	input  wire logic                          I_SRST,
	input  wire logic                          i_st_valid,
	input  wire logic [cebi_pkg::ADDR_W-1:0]   i_st_addr,
	input  wire logic [cebi_pkg::DATA_W-1:0]   i_st_data,
	input  wire logic [3:0]                    i_st_be,
	output logic                               o_st_ready,
	input  wire logic                          i_rd_valid,
	input  wire logic [cebi_pkg::ADDR_W-1:0]   i_rd_addr,
	input  wire logic                          i_rd_quad,
	output logic                               o_rd_ready,
	output logic                               o_rd_valid,
	output logic [cebi_pkg::DATA_W-1:0]        o_rd_data,
	output logic                               o_rd_last,
	output logic                               o_core_en,
	input  wire logic [2*cebi_pkg::REGIONS-1:0] I_PSZ_MAP,
	input  wire logic                          I_EXT_HOLD,
	input  wire logic                          I_BURST_MODE,
	input  wire logic [cebi_pkg::DATA_W-1:0]   I_AD,
	output logic      [cebi_pkg::DATA_W-1:0]   O_AD,
	output logic                               O_AD_OE,
	output logic                               O_ALE,
	output logic [3:0]                         O_ADDR_LO,
	output logic                               O_RD_N,
	output logic                               O_WR_N,
	output logic                               O_CTRL_OE,
	input  wire logic                          I_ACK_N,
	input  wire logic                          I_BUSREQ_N,
	output logic                               O_BUSGNT_N
);
	import cebi_pkg::*;

	localparam int WP = $clog2(WQ_D);   // write queue index width
	localparam int RP = $clog2(RB_D);   // read buffer index width

	////////////////////////////////////////////////////////////////////////
	// helpers: lane steering for narrow ports
	////////////////////////////////////////////////////////////////////////

	// data placed on the low lanes for one write beat
	function automatic logic [31:0] beat_data(input logic [31:0] w, input logic [1:0] psz,
		input logic [1:0] beat);
		logic [31:0] r;
		r = w;
		case (psz)
			PSZ_16:  r = {16'h0, w[16*beat[0] +: 16]};
			PSZ_8:   r = {24'h0, w[8*beat +: 8]};
			default: r = w;
		endcase
		return r;
	endfunction

	// merge one narrow read beat into its word
	function automatic logic [31:0] merge(input logic [31:0] w, input logic [31:0] ad,
		input logic [1:0] psz, input logic [1:0] beat);
		logic [31:0] r;
		r = w;
		case (psz)
			PSZ_16:  r[16*beat[0] +: 16] = ad[15:0];
			PSZ_8:   r[8*beat +: 8] = ad[7:0];
			default: r = ad;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// clock divider: core rate is every other input clock
	////////////////////////////////////////////////////////////////////////

	logic ph_q;     // divider phase
	logic ph_d;     // next divider phase

	// toggle phase each input clock
	always_comb begin
		ph_d = ~ph_q;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			ph_q <= RST_PH;
		end else begin
			ph_q <= ph_d;
		end
	end

	assign o_core_en = ph_q;

	////////////////////////////////////////////////////////////////////////
	// write queue
	////////////////////////////////////////////////////////////////////////

	logic [31:0]  wq_addr_q [WQ_D];  // queued store address
	logic [31:0]  wq_data_q [WQ_D];  // queued store data
	logic [3:0]   wq_be_q   [WQ_D];  // queued byte enables
	logic [31:0]  wq_addr_d [WQ_D];
	logic [31:0]  wq_data_d [WQ_D];
	logic [3:0]   wq_be_d   [WQ_D];
	logic [WP:0]  wq_wp_q;           // fill pointer with wrap bit
	logic [WP:0]  wq_rp_q;           // drain pointer with wrap bit
	logic [WP:0]  wq_wp_d;
	logic [WP:0]  wq_rp_d;
	logic         wq_full;           // all entries occupied
	logic         wq_empty;          // nothing to drain
	logic         wq_push;           // store accepted
	logic         wq_pop;            // head taken by sequencer

	assign wq_full    = (wq_wp_q[WP] != wq_rp_q[WP]) && (wq_wp_q[WP-1:0] == wq_rp_q[WP-1:0]);
	assign wq_empty   = (wq_wp_q == wq_rp_q);
	assign o_st_ready = ~wq_full & ph_q;
	assign wq_push    = i_st_valid & o_st_ready;

	// queue next state: write at tail, advance head on pop
	always_comb begin
		wq_addr_d = wq_addr_q;
		wq_data_d = wq_data_q;
		wq_be_d   = wq_be_q;
		wq_wp_d   = wq_wp_q;
		wq_rp_d   = wq_rp_q;
		if (wq_push) begin
			wq_addr_d[wq_wp_q[WP-1:0]] = i_st_addr;
			wq_data_d[wq_wp_q[WP-1:0]] = i_st_data;
			wq_be_d[wq_wp_q[WP-1:0]]   = i_st_be;
			wq_wp_d = wq_wp_q + 1'b1;
		end
		if (wq_pop) begin
			wq_rp_d = wq_rp_q + 1'b1;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		wq_addr_q <= wq_addr_d;
		wq_data_q <= wq_data_d;
		wq_be_q   <= wq_be_d;
		if (I_SRST) begin
			wq_wp_q <= '0;
			wq_rp_q <= '0;
		end else begin
			wq_wp_q <= wq_wp_d;
			wq_rp_q <= wq_rp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus sequencer, read buffer and pin registers
	////////////////////////////////////////////////////////////////////////

	cebi_state_e  st_q, st_d;        // sequencer state
	logic         wr_q, wr_d;        // current transfer is a write
	logic         quad_q, quad_d;    // current read is a line fill
	logic         burst_q, burst_d;  // burst beats running without acknowledge
	logic [1:0]   psz_q, psz_d;      // port width of current transfer
	logic [31:0]  adr_q, adr_d;      // transfer address
	logic [31:0]  wdat_q, wdat_d;    // store word being split
	logic [3:0]   bcnt_q, bcnt_d;    // beat index within transfer
	logic [4:0]   btot;              // beats in this transfer
	logic [1:0]   rel_q, rel_d;      // release index into read buffer
	logic [31:0]  rb_q [RB_D];       // read buffer words
	logic [31:0]  rb_d [RB_D];
	logic [31:0]  ad_q, ad_d;        // pin data out
	logic         oe_q, oe_d;        // pin drive enable
	logic         ale_q, ale_d;      // address latch strobe
	logic [3:0]   lo_q, lo_d;        // low address outputs
	logic         rdn_q, rdn_d;      // read strobe, low active
	logic         wrn_q, wrn_d;      // write strobe, low active
	logic         coe_q, coe_d;      // control pins driven
	logic         gntn_q, gntn_d;    // bus grant, low active
	logic         rv_q, rv_d;        // read word valid to cache
	logic         rl_q, rl_d;        // last word of release
	logic [31:0]  rdat_q, rdat_d;    // read word to cache
	logic [1:0]   beat;              // beat within current word
	logic [RP-1:0] widx;             // word index of current beat
	logic [3:0]   step;              // low address increment
	logic         last_beat;         // current beat ends the transfer
	logic [1:0]   npsz;              // port width of a new request

	assign o_rd_ready = st_q[0] & ph_q & wq_empty & I_BUSREQ_N;
	assign btot       = (quad_q ? 5'd4 : 5'd1) << psz_q;
	assign last_beat  = ({1'b0, bcnt_q} == btot - 5'd1);

	// beat and word position by port width
	always_comb begin
		case (psz_q)
			PSZ_16: begin
				beat = {1'b0, bcnt_q[0]};
				widx = bcnt_q[2:1];
				step = STEP_16;
			end
			PSZ_8: begin
				beat = bcnt_q[1:0];
				widx = bcnt_q[3:2];
				step = STEP_8;
			end
			default: begin
				beat = 2'h0;
				widx = bcnt_q[1:0];
				step = STEP_32;
			end
		endcase
		// a single read fills the slot it addressed, which is the slot released later
		if (!quad_q) begin
			widx = adr_q[3:2];
		end
	end

	// port width of the region that a new request falls in
	always_comb begin
		if (!wq_empty) begin
			npsz = I_PSZ_MAP[2*wq_addr_q[wq_rp_q[WP-1:0]][31:29] +: 2];
		end else begin
			npsz = I_PSZ_MAP[2*i_rd_addr[31:29] +: 2];
		end
	end

	// sequencer next state
	always_comb begin
		st_d    = st_q;
		wr_d    = wr_q;
		quad_d  = quad_q;
		burst_d = burst_q;
		psz_d   = psz_q;
		adr_d   = adr_q;
		wdat_d  = wdat_q;
		bcnt_d  = bcnt_q;
		rel_d   = rel_q;
		rb_d    = rb_q;
		ad_d    = ad_q;
		oe_d    = oe_q;
		ale_d   = ale_q;
		lo_d    = lo_q;
		rdn_d   = rdn_q;
		wrn_d   = wrn_q;
		coe_d   = coe_q;
		gntn_d  = gntn_q;
		rv_d    = 1'b0;
		rl_d    = 1'b0;
		rdat_d  = rdat_q;
		wq_pop  = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (ph_q && !I_BUSREQ_N) begin
					st_d   = ST_DMA;
					oe_d   = 1'b0;
					coe_d  = 1'b0;
					gntn_d = 1'b0;
				end else if (ph_q && !wq_empty) begin
					wq_pop  = 1'b1;
					st_d    = ST_ADDR;
					wr_d    = 1'b1;
					quad_d  = 1'b0;
					psz_d   = npsz;
					adr_d   = wq_addr_q[wq_rp_q[WP-1:0]];
					wdat_d  = wq_data_q[wq_rp_q[WP-1:0]];
					bcnt_d  = RST_BEAT;
					lo_d    = {wq_addr_q[wq_rp_q[WP-1:0]][3:2], 2'h0};
					ad_d    = {wq_addr_q[wq_rp_q[WP-1:0]][31:4],
						(npsz == PSZ_32) ? wq_be_q[wq_rp_q[WP-1:0]] : BE_ALL};
					oe_d    = 1'b1;
					ale_d   = 1'b1;
				end else if (i_rd_valid && o_rd_ready) begin
					st_d    = ST_ADDR;
					wr_d    = 1'b0;
					quad_d  = i_rd_quad;
					burst_d = 1'b0;
					psz_d   = npsz;
					adr_d   = i_rd_addr;
					bcnt_d  = RST_BEAT;
					lo_d    = i_rd_quad ? LO_QUAD_START : {i_rd_addr[3:2], 2'h0};
					ad_d    = {i_rd_addr[31:4], BE_ALL};
					oe_d    = 1'b1;
					ale_d   = 1'b1;
				end
			end
			ST_ADDR: begin
				if (ph_q) begin
					ale_d = 1'b0;
					if (I_EXT_HOLD) begin
						st_d = ST_HOLD;
					end else begin
						st_d  = ST_XFER;
						ad_d  = beat_data(wdat_q, psz_q, beat);
						oe_d  = wr_q;
						rdn_d = wr_q;
						wrn_d = ~wr_q;
					end
				end
			end
			ST_HOLD: begin
				// address stays on the pins one more half clock past the strobe
				st_d  = ST_XFER;
				ad_d  = beat_data(wdat_q, psz_q, beat);
				oe_d  = wr_q;
				rdn_d = wr_q;
				wrn_d = ~wr_q;
			end
			ST_XFER: begin
				if (ph_q && (!I_ACK_N || burst_q)) begin
					if (!wr_q) begin
						rb_d[widx] = merge(rb_q[widx], I_AD, psz_q, beat);
					end
					if (last_beat) begin
						rdn_d   = 1'b1;
						wrn_d   = 1'b1;
						oe_d    = 1'b0;
						burst_d = 1'b0;
						rel_d   = RST_REL;
						st_d    = wr_q ? ST_IDLE : ST_REL;
					end else begin
						bcnt_d = bcnt_q + 4'h1;
						lo_d   = lo_q + step;
						if (quad_q && I_BURST_MODE) begin
							burst_d = 1'b1;
						end else begin
							st_d  = ST_RECOV;
							rdn_d = 1'b1;
							wrn_d = 1'b1;
						end
					end
				end
			end
			ST_RECOV: begin
				// strobe high for one core clock between handshaked beats
				if (ph_q) begin
					st_d  = ST_XFER;
					ad_d  = beat_data(wdat_q, psz_q, beat);
					rdn_d = wr_q;
					wrn_d = ~wr_q;
				end
			end
			ST_REL: begin
				// only a complete transfer, one word or a whole line fill, is passed on to the cache
				if (ph_q) begin
					rv_d   = 1'b1;
					rdat_d = quad_q ? rb_q[rel_q] : rb_q[adr_q[3:2]];
					rl_d   = !quad_q || (rel_q == 2'(QUAD_WORDS - 1));
					rel_d  = rel_q + 2'h1;
					if (rl_d) begin
						st_d = ST_IDLE;
					end
				end
			end
			ST_DMA: begin
				if (I_BUSREQ_N) begin
					st_d   = ST_IDLE;
					coe_d  = 1'b1;
					gntn_d = 1'b1;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		rb_q <= rb_d;
		if (I_SRST) begin
			st_q    <= ST_IDLE;
			wr_q    <= 1'b0;
			quad_q  <= 1'b0;
			burst_q <= 1'b0;
			psz_q   <= PSZ_32;
			adr_q   <= RST_WORD;
			wdat_q  <= RST_WORD;
			bcnt_q  <= RST_BEAT;
			rel_q   <= RST_REL;
			ad_q    <= RST_WORD;
			oe_q    <= 1'b0;
			ale_q   <= 1'b0;
			lo_q    <= RST_LO;
			rdn_q   <= 1'b1;
			wrn_q   <= 1'b1;
			coe_q   <= 1'b1;
			gntn_q  <= 1'b1;
			rv_q    <= 1'b0;
			rl_q    <= 1'b0;
			rdat_q  <= RST_WORD;
		end else begin
			st_q    <= st_d;
			wr_q    <= wr_d;
			quad_q  <= quad_d;
			burst_q <= burst_d;
			psz_q   <= psz_d;
			adr_q   <= adr_d;
			wdat_q  <= wdat_d;
			bcnt_q  <= bcnt_d;
			rel_q   <= rel_d;
			ad_q    <= ad_d;
			oe_q    <= oe_d;
			ale_q   <= ale_d;
			lo_q    <= lo_d;
			rdn_q   <= rdn_d;
			wrn_q   <= wrn_d;
			coe_q   <= coe_d;
			gntn_q  <= gntn_d;
			rv_q    <= rv_d;
			rl_q    <= rl_d;
			rdat_q  <= rdat_d;
		end
	end

	// pins and cache side straight from registers
	assign O_AD       = ad_q;
	assign O_AD_OE    = oe_q;
	assign O_ALE      = ale_q;
	assign O_ADDR_LO  = lo_q;
	assign O_RD_N     = rdn_q;
	assign O_WR_N     = wrn_q;
	assign O_CTRL_OE  = coe_q;
	assign O_BUSGNT_N = gntn_q;
	assign o_rd_valid = rv_q;
	assign o_rd_data  = rdat_q;
	assign o_rd_last  = rl_q;
endmodule

// ---- tb/cebi_bus_props.sv ----
// port checker of the external bus unit
`timescale 1ns/1ps
module cebi_bus_props #(
	parameter int WQ_D = 4,	// write queue depth
	parameter int RB_D = 4	// read buffer depth
) (
	input wire logic        I_CORE_CLK,
	input wire logic        I_SRST,
	input wire logic        o_core_en,
	input wire logic        i_rd_valid,
	input wire logic        i_rd_quad,
	input wire logic        o_rd_ready,
	input wire logic        o_rd_valid,
	input wire logic        o_rd_last,
	input wire logic        I_EXT_HOLD,
	input wire logic [31:0] O_AD,
	input wire logic        O_AD_OE,
	input wire logic        O_ALE,
	input wire logic [3:0]  O_ADDR_LO,
	input wire logic        O_RD_N,
	input wire logic        O_WR_N,
	input wire logic        O_CTRL_OE,
	input wire logic        I_BUSREQ_N,
	input wire logic        O_BUSGNT_N
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SRST);
	wire quad_take = i_rd_valid && o_rd_ready && i_rd_quad;	// line fill taken
	wire idle_n    = O_RD_N && O_WR_N;	// no strobe low
	////////////////////////////////////////////////////////////////
	sequence s_word; o_rd_valid && !o_rd_last; endsequence
	sequence s_line; s_word ##2 s_word ##2 s_word ##2 (o_rd_valid && o_rd_last); endsequence
	property p_phase; 1 |=> o_core_en != $past(o_core_en); endproperty
	property p_ale2; $rose(O_ALE) |=> O_ALE ##1 !O_ALE; endproperty
	property p_adph; O_ALE |-> O_AD_OE && idle_n && O_CTRL_OE; endproperty
	property p_hold; $fell(O_ALE) && I_EXT_HOLD |-> $stable(O_AD) && idle_n ##1 !idle_n;
	endproperty
	property p_nohold; $fell(O_ALE) && !I_EXT_HOLD |-> !idle_n; endproperty
	property p_excl; O_RD_N || O_WR_N; endproperty
	property p_gnt; !O_BUSGNT_N |-> !O_AD_OE && !O_CTRL_OE; endproperty
	property p_rel; !O_BUSGNT_N && I_BUSREQ_N |-> ##[1:2] O_BUSGNT_N; endproperty
	property p_quad; quad_take |-> ##[1:2] (O_ALE && O_ADDR_LO == 4'h0) ##[1:300] s_line;
	endproperty
	property p_last; o_rd_last |-> o_rd_valid ##1 !o_rd_valid; endproperty
	////////////////////////////////////////////////////////////////
	a_phase: assert property (p_phase) else $error("core enable not alternating");
	a_ale2: assert property (p_ale2) else $error("latch strobe width wrong");
	a_adph: assert property (p_adph) else $error("address phase not clean");
	a_hold: assert property (p_hold) else $error("extended hold missing");
	a_nohold: assert property (p_nohold) else $error("data phase late");
	a_excl: assert property (p_excl) else $error("both strobes low");
	a_gnt: assert property (p_gnt) else $error("pins driven in grant");
	a_rel: assert property (p_rel) else $error("grant not withdrawn");
	a_quad: assert property (p_quad) else $error("line fill wrong");
	a_last: assert property (p_last) else $error("last word pulse wrong");
endmodule
bind cebi_bus_unit cebi_bus_props #(.WQ_D(WQ_D), .RB_D(RB_D)) props_u (
	.I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .o_core_en(o_core_en),
	.i_rd_valid(i_rd_valid), .i_rd_quad(i_rd_quad), .o_rd_ready(o_rd_ready),
	.o_rd_valid(o_rd_valid), .o_rd_last(o_rd_last), .I_EXT_HOLD(I_EXT_HOLD),
	.O_AD(O_AD), .O_AD_OE(O_AD_OE), .O_ALE(O_ALE), .O_ADDR_LO(O_ADDR_LO),
	.O_RD_N(O_RD_N), .O_WR_N(O_WR_N), .O_CTRL_OE(O_CTRL_OE),
	.I_BUSREQ_N(I_BUSREQ_N), .O_BUSGNT_N(O_BUSGNT_N)
);

// ---- tb/cebi_mem_model.sv ----
// memory partner: acks after a wait, serves read beats
`timescale 1ns/1ps
module cebi_mem_model (
	input  wire logic        i_clk,	// core clock
	input  wire logic        i_rd_n,	// read strobe
	input  wire logic        i_wr_n,	// write strobe
	input  wire logic [3:0]  i_lo,	// low address
	input  wire logic [3:0]  i_wait,	// clocks before ack
	output logic      [31:0] o_ad,	// read beat
	output logic             o_ack_n	// acknowledge
);
	logic [3:0]  cnt_q  = 4'h0;	// clocks strobe low
	logic [31:0] last_q = 32'h0;	// last beat driven
	logic        ack_q  = 1'b1;	// registered ack
	wire         low    = !(i_rd_n && i_wr_n);	// a strobe is low
	wire  [31:0] w      = 32'h10203040 + {4{6'h0, i_lo[3:2]}};	// word at lo
	// ack after the wait, lifted one clock after the strobe rises
	always_ff @(posedge i_clk) begin
		cnt_q <= !low ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
		ack_q <= !(low && cnt_q >= i_wait);
		if (!i_rd_n) last_q <= o_ad;
	end
	assign o_ack_n = ack_q;
	// beat on low lanes; released bus shows inverse
	assign o_ad = i_rd_n ? ~last_q : w >> {i_lo[1:0], 3'h0};
endmodule

// ---- tb/cebi_bus_unit_tb.sv ----
// self-checking bench of the external bus unit
`timescale 1ns/1ps
module cebi_bus_unit_tb;
	logic        clk, srst, st_valid, rd_valid, rd_quad, ext_hold, burst, busreq_n;
	logic [31:0] st_addr, st_data, rd_addr;
	logic [3:0]  st_be, wait_n;
	logic [15:0] psz_map;
	wire         st_ready, rd_ready, rd_v, rd_last, core_en, ad_oe, ale, rd_n, wr_n;
	wire         ctrl_oe, ack_n, gnt_n;
	wire  [31:0] rd_data, ad_o, ad_i;
	wire  [3:0]  lo;
	int          num_errors, comparisons;
	logic [35:0] beats[$];	// completed write beats
	cebi_bus_unit dut_u (
		.I_CORE_CLK(clk), .I_SRST(srst), .i_st_valid(st_valid), .i_st_addr(st_addr),
		.i_st_data(st_data), .i_st_be(st_be), .o_st_ready(st_ready),
		.i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .i_rd_quad(rd_quad),
		.o_rd_ready(rd_ready), .o_rd_valid(rd_v), .o_rd_data(rd_data),
		.o_rd_last(rd_last), .o_core_en(core_en), .I_PSZ_MAP(psz_map),
		.I_EXT_HOLD(ext_hold), .I_BURST_MODE(burst), .I_AD(ad_i), .O_AD(ad_o),
		.O_AD_OE(ad_oe), .O_ALE(ale), .O_ADDR_LO(lo), .O_RD_N(rd_n), .O_WR_N(wr_n),
		.O_CTRL_OE(ctrl_oe), .I_ACK_N(ack_n), .I_BUSREQ_N(busreq_n), .O_BUSGNT_N(gnt_n)
	);
	cebi_mem_model mem_u (
		.i_clk(clk), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_lo(lo), .i_wait(wait_n),
		.o_ad(ad_i), .o_ack_n(ack_n)
	);
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// log each acked write beat
	always @(posedge clk) if (core_en && !wr_n && !ack_n) beats.push_back({lo, ad_o});
	function automatic logic [31:0] mword(logic [1:0] k);
		return 32'h10203040 + {4{6'h0, k}};
	endfunction
	task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_flag(string n, logic e, logic g);
		chk_word(n, {31'h0, e}, {31'h0, g});
	endtask
	task automatic end_sim();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic store(logic [31:0] a, logic [31:0] d);
		int n;
		@(posedge clk);
		st_valid <= 1'b1;
		st_addr <= a;
		st_data <= d;
		n = 0;
		do begin @(posedge clk); n++; end while (!st_ready && n < 60);
		st_valid <= 1'b0;
		chk_flag("store taken", 1'b1, st_ready);
	endtask
	task automatic wait_beats(int b);
		for (int i = 0; i < 800 && beats.size() < b; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk_word("write beats", b, beats.size());
	endtask
	task automatic store_split(logic [2:0] r, int s);
		logic [31:0] d, m;
		d = 32'hc3a55a3c ^ {29'h0, r};
		m = (s == 4) ? 32'hffffffff : (32'h1 << (8 * s)) - 1;
		beats.delete();
		store({r, 29'h104}, d);
		wait_beats(4 / s);
		for (int k = 0; k < 4 / s && k < beats.size(); k++) begin
			chk_word("beat lo", 4 + k * s, {28'h0, beats[k][35:32]});
			chk_word("beat data", (d >> (8 * k * s)) & m, beats[k][31:0] & m);
		end
	endtask
	task automatic rd(logic [31:0] a, logic q);
		int n;
		logic [1:0] k;
		@(posedge clk);
		rd_valid <= 1'b1;
		rd_addr <= a;
		rd_quad <= q;
		n = 0;
		do begin @(posedge clk); n++; end while (!rd_ready && n < 60);
		rd_valid <= 1'b0;
		k = q ? 2'h0 : a[3:2];
		for (int i = 0; i < (q ? 4 : 1); i++) begin
			n = 0;
			do begin @(posedge clk); n++; end while (!rd_v && n < 600);
			chk_word("read word", mword(k), rd_data);
			chk_flag("last word", i == (q ? 3 : 0), rd_last);
			k++;
		end
	endtask
	task automatic t_reads();
		for (int b = 0; b < 2; b++) begin
			burst <= b[0];
			for (int r = 0; r < 3; r++) begin
				rd({r[2:0], 29'h108}, 1'b0);
				rd({r[2:0], 29'h100}, 1'b1);
			end
		end
		burst <= 1'b0;
	endtask
	task automatic t_full();
		int n;
		beats.delete();
		@(posedge clk);
		busreq_n <= 1'b0;
		for (n = 0; n < 20 && gnt_n; n++) @(posedge clk);
		chk_flag("grant", 1'b0, gnt_n);
		chk_flag("read refused", 1'b0, rd_ready);
		for (int i = 0; i < 4; i++) store(32'h104, 32'h1000 + i);
		@(posedge clk);
		st_valid <= 1'b1;
		st_data <= 32'h1004;
		repeat (8) begin @(posedge clk); chk_flag("full refuses", 1'b0, st_ready); end
		busreq_n <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (!st_ready && n < 200);
		st_valid <= 1'b0;
		wait_beats(5);
		for (int i = 0; i < 5 && i < beats.size(); i++)
			chk_word("queue order", 32'h1000 + i, beats[i][31:0]);
		chk_flag("grant released", 1'b1, gnt_n);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		{st_valid, rd_valid, rd_quad, ext_hold, burst} = 5'h0;
		busreq_n = 1'b1;
		{st_addr, st_data, rd_addr} = 96'h0;
		st_be = 4'hf;
		wait_n = 4'h2;
		psz_map = 16'h0024;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int r = 0; r < 3; r++) store_split(r[2:0], 4 >> r);
		ext_hold <= 1'b1;
		store_split(3'h1, 2);
		ext_hold <= 1'b0;
		t_reads();
		t_full();
		end_sim();
	end
	// cut a hang short
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		end_sim();
	end
endmodule
